// file: sacs_sequencer.sv
// Successive-approximation conversion sequencer: periods, bits, result, flag.
// Assumes pins arrive asynchronously and the comparator output settles per period.
module sacs_sequencer
  import sacs_pkg::*;
#(
  parameter int DIV = SACS_DIV_CYCLES
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // Mode: high selects the internal, stoppable conversion clock
  input wire logic internal_clock_mode,
  // Host control pins
  input wire logic conversion_trigger_n,
  input wire logic valid_flag_clear_n,
  input wire logic upper_bits_out_enable_n,
  input wire logic lower_bits_out_enable_n,
  // Analog front end
  input wire logic comparator_high,
  output logic track_input,
  output logic [SACS_RES_BITS-1:0] dac_bits,
  // Result pins
  output logic [SACS_RES_BITS-1:0] result_out,
  output logic [SACS_RES_BITS-1:0] result_oe,
  output logic result_valid_flag,
  output logic conv_clock_running
);
  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  logic [3:0] sy1_q, sy2_q;
  logic trig_n_s, upper_n_s, lower_n_s, comp_s;

  // Two flops on the trigger, both output enables and the comparator
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      sy1_q <= 4'hF;
      sy2_q <= 4'hF;
    end else begin
      sy1_q <= {conversion_trigger_n, upper_bits_out_enable_n,
                lower_bits_out_enable_n, comparator_high};
      sy2_q <= sy1_q;
    end
  end
  assign trig_n_s = sy2_q[3];
  assign upper_n_s = sy2_q[2];
  assign lower_n_s = sy2_q[1];
  assign comp_s = sy2_q[0];

  // ----------------------------------------------------------------
  // Period state
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {SACS_RUN, SACS_WAIT, SACS_STOPPED} sacs_mode_t;
  sacs_mode_t mode_q;
  logic [3:0] period_q;
  logic tick, stop_clk, restart, released_q, armed;
  logic [SACS_RES_BITS-1:0] sar_q, res_q;
  sacs_bus_t bus;

  assign stop_clk = (mode_q == SACS_STOPPED);
  assign restart = stop_clk && !trig_n_s;

  sacs_tick_div #(.DIV(DIV)) u_div (
    .core_clk(core_clk),
    .rst(rst),
    .stop(stop_clk),
    .restart(restart),
    .tick(tick)
  );

  // Trigger released before period 1 and not reapplied in it
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      released_q <= 1'b0;
    end else if (tick && period_q == SACS_P_LAST) begin
      released_q <= trig_n_s;
    end else if (period_q == SACS_P_FIRST && !trig_n_s) begin
      released_q <= 1'b0;
    end
  end
  assign armed = !released_q || !trig_n_s;

  // Period advance on conversion-clock edges only
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      period_q <= SACS_P_RESET;
      mode_q <= SACS_RUN;
    end else begin
      unique case (mode_q)
        SACS_RUN: begin
          if (tick) begin
            if (period_q == SACS_P_LAST) begin
              period_q <= SACS_P_FIRST;
            end else if (period_q == SACS_P_FIRST && !armed) begin
              period_q <= SACS_P_WAIT;
              mode_q <= internal_clock_mode ? SACS_STOPPED : SACS_WAIT;
            end else begin
              period_q <= period_q + 4'h1;
            end
          end
        end
        SACS_WAIT: begin
          // External clock keeps ticking; advance on first qualified edge
          if (tick && !trig_n_s) begin
            period_q <= SACS_P_TRACK_END;
            mode_q <= SACS_RUN;
          end
        end
        SACS_STOPPED: begin
          // Divider restarts full, so period 2 low phase stretches
          if (!trig_n_s) begin
            mode_q <= SACS_RUN;
          end
        end
        default: begin
          mode_q <= SACS_RUN;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Successive approximation and result transfer
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      sar_q <= '0;
      res_q <= '0;
    end else if (tick && mode_q == SACS_RUN) begin
      if (period_q >= SACS_P_MSB) begin
        // Period 4 decides bit 9 ... period 13 decides bit 0
        sar_q[SACS_RES_BITS-1-(period_q-SACS_P_MSB)] <= comp_s;
      end
      if (period_q == SACS_P_LAST) begin
        res_q <= sar_q;
        res_q[0] <= comp_s;
        sar_q <= '0;
      end
    end
  end

  // Trial word: decided bits plus the bit under test
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      dac_bits <= '0;
      track_input <= 1'b1;
    end else begin
      track_input <= (period_q < SACS_P_MSB);
      dac_bits <= sar_q;
      if (period_q >= SACS_P_MSB) begin
        dac_bits[SACS_RES_BITS-1-(period_q-SACS_P_MSB)] <= 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // Result-valid flag; clear pin resets it without a clock
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk or posedge rst or negedge valid_flag_clear_n) begin
    if (rst) begin
      result_valid_flag <= 1'b0;
    end else if (!valid_flag_clear_n) begin
      result_valid_flag <= 1'b0;
    end else if (tick && mode_q == SACS_RUN && period_q == SACS_P_LAST) begin
      result_valid_flag <= 1'b1;
    end else if (mode_q != SACS_RUN && !trig_n_s) begin
      result_valid_flag <= 1'b0;
    end else if (tick && mode_q == SACS_RUN && period_q == SACS_P_FIRST && armed) begin
      result_valid_flag <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Three-state result pins; host may latch on flag fall
  // ----------------------------------------------------------------
  always_comb begin
    bus.data = res_q;
    bus.oe = {{(SACS_RES_BITS-SACS_UPPER_LSB){!upper_n_s}},
              {SACS_UPPER_LSB{!lower_n_s}}};
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      result_out <= '0;
      result_oe <= '0;
      conv_clock_running <= 1'b1;
    end else begin
      result_out <= bus.data;
      result_oe <= bus.oe;
      conv_clock_running <= !stop_clk;
    end
  end

  // ----------------------------------------------------------------
  // Check helpers: conversion length and period strobes
  // ----------------------------------------------------------------
  // A free-run conversion is thirteen periods of DIV core cycles each
  localparam int CONV_CYCLES = int'(SACS_P_LAST) * DIV;
  localparam int CCW = $clog2(CONV_CYCLES + 1);
  logic [CCW-1:0] conv_cnt_q;
  logic free_q, end_tick, p1_tick;

  // Period strobes shared by the checks below
  assign end_tick = tick && mode_q == SACS_RUN && period_q == SACS_P_LAST;
  assign p1_tick = tick && mode_q == SACS_RUN && period_q == SACS_P_FIRST;

  // Core cycles since the last transfer; saturates so a long stop cannot wrap it
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      conv_cnt_q <= '0;
    end else if (end_tick) begin
      conv_cnt_q <= CCW'(1);
    end else if (conv_cnt_q != CCW'(CONV_CYCLES)) begin
      conv_cnt_q <= conv_cnt_q + 1'b1;
    end
  end

  // High only while a whole conversion ran without a wait or a stop;
  // a stretched period 2 would otherwise look like a length fault
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      free_q <= 1'b0;
    end else if (end_tick) begin
      free_q <= 1'b1;
    end else if (mode_q != SACS_RUN) begin
      free_q <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  // Period bounds, wrap and conversion length
  a_period_range: assert property (@(posedge core_clk) disable iff (rst)
    period_q >= SACS_P_FIRST && period_q <= SACS_P_LAST) else $error("period out of range");
  a_wrap_to_one: assert property (@(posedge core_clk) disable iff (rst)
    tick && mode_q == SACS_RUN && period_q == SACS_P_LAST |=> period_q == SACS_P_FIRST)
    else $error("no wrap to period one");
  a_conv_length: assert property (@(posedge core_clk) disable iff (rst)
    end_tick && free_q |-> conv_cnt_q == CCW'(CONV_CYCLES))
    else $error("free-run conversion length wrong");

  // Track window
  a_track_window: assert property (@(posedge core_clk) disable iff (rst)
    period_q >= SACS_P_MSB |=> !track_input) else $error("tracking during hold");
  a_track_early: assert property (@(posedge core_clk) disable iff (rst)
    period_q < SACS_P_MSB |=> track_input) else $error("not tracking in early periods");

  // Bit decisions and result transfer
  a_msb_first: assert property (@(posedge core_clk) disable iff (rst)
    tick && mode_q == SACS_RUN && period_q == SACS_P_MSB
    |=> sar_q[SACS_RES_BITS-1] == $past(comp_s)) else $error("msb not decided first");
  a_result_load: assert property (@(posedge core_clk) disable iff (rst)
    tick && mode_q == SACS_RUN && period_q == SACS_P_LAST |=> res_q[0] == $past(comp_s))
    else $error("lsb not transferred");
  a_result_hold: assert property (@(posedge core_clk) disable iff (rst)
    !end_tick |=> $stable(res_q)) else $error("result changed mid conversion");
  a_out_follows: assert property (@(posedge core_clk) disable iff (rst)
    ##1 result_out == $past(res_q)) else $error("result pins do not follow");

  // Result-valid flag
  a_flag_rise: assert property (@(posedge core_clk) disable iff (rst)
    tick && mode_q == SACS_RUN && period_q == SACS_P_LAST && valid_flag_clear_n
    |=> result_valid_flag || !valid_flag_clear_n) else $error("flag did not rise");
  a_flag_fall: assert property (@(posedge core_clk) disable iff (rst)
    p1_tick && armed |=> !result_valid_flag) else $error("flag not lowered in period two");
  a_clear_wins: assert property (@(posedge core_clk) disable iff (rst)
    !valid_flag_clear_n |-> !result_valid_flag) else $error("flag high under clear");
  a_wait_drop: assert property (@(posedge core_clk) disable iff (rst)
    mode_q == SACS_WAIT && !trig_n_s |=> !result_valid_flag)
    else $error("trigger did not drop flag");

  // Internal stop and external wait
  a_stop_entry: assert property (@(posedge core_clk) disable iff (rst)
    $rose(stop_clk) |-> $past(p1_tick)) else $error("clock stopped outside period one");
  a_stop_hold: assert property (@(posedge core_clk) disable iff (rst)
    stop_clk |-> period_q == SACS_P_WAIT && !tick) else $error("stopped clock ticked");
  a_stop_flag: assert property (@(posedge core_clk) disable iff (rst)
    stop_clk && $past(stop_clk) && trig_n_s && valid_flag_clear_n && $past(result_valid_flag)
    |-> result_valid_flag) else $error("flag lost while stopped");
  a_stop_track: assert property (@(posedge core_clk) disable iff (rst)
    stop_clk |-> track_input) else $error("not tracking while stopped");
  a_restart_drop: assert property (@(posedge core_clk) disable iff (rst)
    stop_clk && !trig_n_s |=> !result_valid_flag && !stop_clk)
    else $error("trigger did not restart");
  a_wait_hold: assert property (@(posedge core_clk) disable iff (rst)
    mode_q == SACS_WAIT && trig_n_s |=> mode_q == SACS_WAIT && period_q == SACS_P_WAIT)
    else $error("wait left without trigger");
  a_wait_advance: assert property (@(posedge core_clk) disable iff (rst)
    mode_q == SACS_WAIT && tick && !trig_n_s |=> period_q == SACS_P_TRACK_END)
    else $error("wait did not advance");
  a_trig_window: assert property (@(posedge core_clk) disable iff (rst)
    period_q != SACS_P_LAST && period_q != SACS_P_FIRST |=> $stable(released_q))
    else $error("trigger sampled mid conversion");

  // Output enables
  a_oe_split: assert property (@(posedge core_clk) disable iff (rst)
    ##1 result_oe[1:0] == {2{!$past(lower_n_s)}}) else $error("lower enable wrong");
  a_upper_oe: assert property (@(posedge core_clk) disable iff (rst)
    ##1 result_oe[SACS_RES_BITS-1:SACS_UPPER_LSB]
    == {(SACS_RES_BITS-SACS_UPPER_LSB){!$past(upper_n_s)}}) else $error("upper enable wrong");

  // Main scenarios
  c_free_wrap: cover property (@(posedge core_clk) disable iff (rst)
    end_tick && free_q ##1 period_q == SACS_P_FIRST);
  c_stopped: cover property (@(posedge core_clk) disable iff (rst) restart);
  c_ext_wait: cover property (@(posedge core_clk) disable iff (rst)
    mode_q == SACS_WAIT ##1 mode_q == SACS_RUN);
  c_clear_held: cover property (@(posedge core_clk) disable iff (rst)
    end_tick && !valid_flag_clear_n);
  c_stretch: cover property (@(posedge core_clk) disable iff (rst)
    restart ##1 period_q == SACS_P_WAIT && !stop_clk);
endmodule : sacs_sequencer

// file: sacs_pkg.sv
// Package for the converter conversion sequencer: period numbers, widths, carriers.
// Assumes one 100 MHz core clock; conversion periods come from an enable divider.
package sacs_pkg;
  // ----------------------------------------------------------------
  // Sequence constants
  // ----------------------------------------------------------------
  localparam int SACS_RES_BITS = 10;
  localparam logic [3:0] SACS_P_FIRST = 4'h1;
  localparam logic [3:0] SACS_P_WAIT = 4'h2;
  localparam logic [3:0] SACS_P_TRACK_END = 4'h3;
  localparam logic [3:0] SACS_P_MSB = 4'h4;
  localparam logic [3:0] SACS_P_LAST = 4'hD;
  localparam logic [3:0] SACS_P_RESET = 4'h1;
  localparam int SACS_CORE_MHZ = 100;
  localparam int SACS_CONV_KHZ = 1000;
  localparam int SACS_DIV_CYCLES = SACS_CORE_MHZ * 1000 / SACS_CONV_KHZ;
  localparam int SACS_UPPER_LSB = 2;

  // Result word and its output enables travel together
  typedef struct packed {
    logic [SACS_RES_BITS-1:0] data;
    logic [SACS_RES_BITS-1:0] oe;
  } sacs_bus_t;
endpackage : sacs_pkg

// file: sacs_tick_div.sv
// Conversion-clock divider: one-cycle enable pulse per conversion period.
// Assumes a single core clock; the stop input holds the divider count at zero.
module sacs_tick_div
  import sacs_pkg::*;
#(
  parameter int DIV = SACS_DIV_CYCLES
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // Control
  input wire logic stop,
  input wire logic restart,
  output logic tick
);
  localparam int CW = $clog2(DIV + 1);
  logic [CW-1:0] cnt_q;

  // ----------------------------------------------------------------
  // Period counter; a restart begins a fresh full period
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      cnt_q <= '0;
    end else if (restart || stop) begin
      cnt_q <= '0;
    end else if (cnt_q == CW'(DIV - 1)) begin
      cnt_q <= '0;
    end else begin
      cnt_q <= cnt_q + 1'b1;
    end
  end

  assign tick = !stop && !restart && (cnt_q == CW'(DIV - 1));
endmodule : sacs_tick_div

// file: sacs_host_model.sv
// Far-side model: comparator front end plus a host that reads result words.
// Assumes trial words on dac_bits, a level valid flag and per-bit drive enables.
module sacs_host_model
  import sacs_pkg::*;
(
  // Analog side
  input wire logic [SACS_RES_BITS-1:0] analog_code,
  input wire logic [SACS_RES_BITS-1:0] dac_bits,
  output logic comparator_high,
  // Result side
  input wire logic result_valid_flag,
  input wire logic [SACS_RES_BITS-1:0] result_out,
  input wire logic [SACS_RES_BITS-1:0] result_oe,
  output logic [SACS_RES_BITS-1:0] captured
);
  timeunit 1ns;
  timeprecision 1ps;
  // Ideal comparator: keep the trial bit when the input is at or above it
  assign comparator_high = (analog_code >= dac_bits);
  // Floating bits have no pull here, so show them inverted to expose a stale read
  logic [SACS_RES_BITS-1:0] pins;
  assign pins = (result_out & result_oe) | (~result_out & ~result_oe);
  // Latch on the trailing edge; the leading edge gives no setup margin
  always @(negedge result_valid_flag) begin
    captured <= pins;
  end
endmodule : sacs_host_model

// file: tb_top.sv
// Testbench: free run, clear, enables, stop and external wait of the sequencer.
// Assumes a short period divider so that each free-run conversion takes 13 * DIV cycles.
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import sacs_pkg::*;
  localparam int DIV = 4;
  localparam logic [SACS_RES_BITS-1:0] CONV = 13 * DIV;
  localparam logic [SACS_RES_BITS-1:0] TRK = 3 * DIV;
  logic core_clk = 1'b0;
  logic rst = 1'b1;
  logic mode = 1'b1;
  logic trig_n = 1'b0;
  logic clr_n = 1'b1;
  logic up_n = 1'b0;
  logic lo_n = 1'b0;
  logic [SACS_RES_BITS-1:0] analog = 10'h000;
  logic comp, track, flag, running;
  logic [SACS_RES_BITS-1:0] dac, res, oe, cap, code, cyc, trk;
  logic [SACS_RES_BITS-1:0] corner [4] = '{10'h000, 10'h3FF, 10'h200, 10'h1FF};
  int n_fail = 0;
  int tests_run = 0;
  int seed = 32'h3c1a;
  int i, m;

  // ------------------------------------------------------------
  // Clock, design and far side
  // ------------------------------------------------------------
  always #5 core_clk = ~core_clk;
  sacs_sequencer #(.DIV(DIV)) dut (
    .core_clk(core_clk), .rst(rst), .internal_clock_mode(mode),
    .conversion_trigger_n(trig_n), .valid_flag_clear_n(clr_n),
    .upper_bits_out_enable_n(up_n), .lower_bits_out_enable_n(lo_n),
    .comparator_high(comp), .track_input(track), .dac_bits(dac),
    .result_out(res), .result_oe(oe), .result_valid_flag(flag),
    .conv_clock_running(running)
  );
  sacs_host_model host (
    .analog_code(analog), .dac_bits(dac), .comparator_high(comp),
    .result_valid_flag(flag), .result_out(res), .result_oe(oe), .captured(cap)
  );

  // ------------------------------------------------------------
  // Tasks
  // ------------------------------------------------------------
  task automatic check(input logic [SACS_RES_BITS-1:0] seen, input logic [9:0] exp);
    tests_run++;
    if (seen !== exp) begin
      n_fail++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  // Expected drive enables: each active-low enable covers its own bit group
  function automatic logic [SACS_RES_BITS-1:0] exp_oe(input logic up, input logic lo);
    return {{(SACS_RES_BITS-SACS_UPPER_LSB){~up}}, {SACS_UPPER_LSB{~lo}}};
  endfunction : exp_oe

  // What the host reads: driven bits as sent, floating bits inverted
  function automatic logic [SACS_RES_BITS-1:0] pin_view(input logic [SACS_RES_BITS-1:0] word,
                                                         input logic [SACS_RES_BITS-1:0] en);
    return (word & en) | (~word & ~en);
  endfunction : pin_view

  // Bounded wait for a fresh rise of the flag, sampled on falling edges
  task automatic wait_rise();
    int k;
    for (k = 0; k < 4 * CONV && flag !== 1'b0; k++) @(negedge core_clk);
    for (k = 0; k < 4 * CONV && flag !== 1'b1; k++) @(negedge core_clk);
    check(10'(flag), 10'h001);
  endtask : wait_rise

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : print_verdict

  // Watchdog: the whole run needs well under 10k cycles
  initial begin
    #100000;
    n_fail++;
    print_verdict();
  end

  // ------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------
  initial begin
    repeat (4) @(posedge core_clk);
    rst <= 1'b0;
    // Free run: corner codes first, then random ones
    for (i = 0; i < 10; i++) begin
      if (i < 4) code = corner[i];
      else code = 10'($random(seed));
      @(posedge core_clk);
      analog <= code;
      wait_rise();
      @(negedge core_clk);
      check(res, code);
      cyc = 10'h001;
      trk = 10'(track);
      while (!(flag === 1'b1 && cyc > DIV) && cyc < 2 * CONV) begin
        @(negedge core_clk);
        cyc++;
        trk += 10'(track);
      end
      check(cyc, CONV);
      check(trk, TRK);
      repeat (DIV + 1) @(negedge core_clk);
      check(10'(flag), 10'h000);
      check(cap, code);
    end
    // Clear low drops the flag at once and keeps it down over a rise
    wait_rise();
    @(posedge core_clk);
    clr_n <= 1'b0;
    @(negedge core_clk);
    check(10'(flag), 10'h000);
    trk = 10'h000;
    repeat (CONV + DIV) begin
      @(negedge core_clk);
      trk += 10'(flag);
    end
    check(trk, 10'h000);
    @(posedge core_clk);
    clr_n <= 1'b1;
    wait_rise();
    // Every combination of the two output enables
    for (i = 0; i < 4; i++) begin
      @(posedge core_clk);
      up_n <= i[1];
      lo_n <= i[0];
      repeat (4) @(negedge core_clk);
      check(oe, exp_oe(i[1], i[0]));
      // Host latch at the next flag fall sees enabled groups as sent, floating groups inverted
      wait_rise();
      repeat (DIV + 1) @(negedge core_clk);
      check(cap, pin_view(code, exp_oe(i[1], i[0])));
    end
    // External wait, then internal stop; each restarted by a trigger
    for (m = 0; m < 2; m++) begin
      code = 10'($random(seed));
      @(posedge core_clk);
      mode <= m[0];
      trig_n <= 1'b0;
      wait_rise();
      @(posedge core_clk);
      trig_n <= 1'b1;
      wait_rise();
      repeat (3 * DIV) @(negedge core_clk);
      check(10'(running), 10'(!m[0]));
      check({8'h00, flag, track}, 10'h003);
      @(posedge core_clk);
      analog <= code;
      trig_n <= 1'b0;
      // Held over a whole period so an external tick sees it
      repeat (DIV + 2) @(posedge core_clk);
      trig_n <= 1'b1;
      repeat (2) @(negedge core_clk);
      check({8'h00, flag, running}, 10'h001);
      wait_rise();
      @(negedge core_clk);
      check(res, code);
    end
    print_verdict();
  end
endmodule : tb_top
